// [rtl/sbcwd_defines.vh]
`ifndef SBCWD_DEFINES_VH
`define SBCWD_DEFINES_VH
`define SBCWD_FRAME_BITS 16
`define SBCWD_ADDR_WDS 3'h0
`define SBCWD_ADDR_MODE 3'h1
`define SBCWD_ADDR_HI 15
`define SBCWD_ADDR_LO 13
`define SBCWD_RO_BIT 12
`define SBCWD_WMC_BIT 11
`define SBCWD_NWP_HI 10
`define SBCWD_NWP_LO 8
`define SBCWD_WOS_BIT 7
`define SBCWD_V1S_BIT 6
`define SBCWD_V2S_BIT 5
`define SBCWD_WAKE_IN1_LEVEL_BIT 4
`define SBCWD_WAKE_IN2_LEVEL_BIT 3
`define SBCWD_MC_HI 11
`define SBCWD_MC_LO 10
`define SBCWD_NWP_RESET 3'h4
`define SBCWD_MS_RESET 13'h0080
`define SBCWD_MC_STANDBY 2'h0
`define SBCWD_MC_SLEEP 2'h1
`define SBCWD_MC_NORM_V2OFF 2'h2
`define SBCWD_MC_NORM_V2ON 2'h3
`define SBCWD_WD_OFF 2'h0
`define SBCWD_WD_WINDOW 2'h1
`define SBCWD_WD_TIMEOUT 2'h2
`endif

// [rtl/sbcwd_regs.v]
`include "sbcwd_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module sbcwd_regs #(
  parameter FRAME_W = `SBCWD_FRAME_BITS
) (
  input wire clk_sys,
  input wire rst_n,
  input wire spi_cs_n,
  input wire spi_sck,
  input wire spi_sdi,
  output reg spi_sdo,
  output reg spi_sdo_oe,
  input wire wdog_disable_input,
  input wire main_reg_uv,
  input wire xcvr_reg_uv,
  input wire local_wake_input_1,
  input wire local_wake_input_2,
  input wire wake_event,
  output reg [1:0] wdog_run_mode_q,
  output reg [2:0] wdog_period_q,
  output reg [12:0] wdog_period_ms_q,
  output reg sw_reset_q,
  output reg [1:0] op_mode_q,
  output reg main_reg_en_q,
  output reg xcvr_reg_en_q
);
  // two-stage synchronisers; stage one read only by stage two
  reg [8:0] s1_q;
  reg [8:0] s2_q;
  reg sck_prev_q;
  reg [FRAME_W-1:0] rx_q;
  reg [FRAME_W-1:0] tx_q;
  reg [4:0] cnt_q;
  reg cs_prev_q;
  reg wdog_mode_sel_q;
  reg [2:0] wdog_period_code_q;
  reg [1:0] op_mode_field_q;
  wire cs_n_s = s2_q[0];
  wire sck_s = s2_q[1];
  wire sdi_s = s2_q[2];
  wire wdog_disable_input_s = s2_q[3];
  wire v1uv_s = s2_q[4];
  wire v2uv_s = s2_q[5];
  wire local_wake_input_1_s = s2_q[6];
  wire local_wake_input_2_s = s2_q[7];
  wire wake_ev_s = s2_q[8];
  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;
  wire frame_start = ~cs_n_s & cs_prev_q;
  wire frame_end = cs_n_s & ~cs_prev_q;
  // counter width is fixed at five bits, enough for frames up to 31 bits
  localparam [4:0] FRAME_CNT = FRAME_W;
  wire bit_taken = ~cs_n_s & sck_fall & (cnt_q != FRAME_CNT);
  // the reply is loaded as the third header bit arrives
  wire addr_known = bit_taken & (cnt_q == 5'h02);
  // short frames are thrown away whole; long ones keep their first FRAME_W bits
  wire frame_ok = frame_end & (cnt_q == FRAME_CNT);
  wire write_ok = frame_ok & ~rx_q[`SBCWD_RO_BIT];
  wire [2:0] rx_addr = rx_q[`SBCWD_ADDR_HI:`SBCWD_ADDR_LO];

  function [12:0] period_ms;
    input [2:0] code;
    begin
      case (code)
        3'h6: period_ms = 13'h0400;
        3'h7: period_ms = 13'h1000;
        default: period_ms = 13'h0008 << code;
      endcase
    end
  endfunction

  function [FRAME_W-1:0] read_word;
    input [2:0] addr;
    begin
      read_word = {FRAME_W{1'b0}};
      read_word[`SBCWD_ADDR_HI:`SBCWD_ADDR_LO] = addr;
      if (addr == `SBCWD_ADDR_WDS)
      begin
        read_word[`SBCWD_WMC_BIT] = wdog_mode_sel_q;
        read_word[`SBCWD_NWP_HI:`SBCWD_NWP_LO] = wdog_period_code_q;
        read_word[`SBCWD_WOS_BIT] = wdog_disable_input_s;
        read_word[`SBCWD_V1S_BIT] = v1uv_s;
        read_word[`SBCWD_V2S_BIT] = v2uv_s;
        read_word[`SBCWD_WAKE_IN1_LEVEL_BIT] = local_wake_input_1_s;
        read_word[`SBCWD_WAKE_IN2_LEVEL_BIT] = local_wake_input_2_s;
        // reserved 2:0 stay zero
      end
      else if (addr == `SBCWD_ADDR_MODE)
        read_word[`SBCWD_MC_HI:`SBCWD_MC_LO] = op_mode_field_q;
    end
  endfunction

  reg [1:0] run_mode_d;
  // sleep and any undecoded state leave the watchdog off
  always @*
  begin
    run_mode_d = `SBCWD_WD_OFF;
    if (!wdog_disable_input_s)
    begin
      case (op_mode_field_q)
        `SBCWD_MC_NORM_V2OFF,
        `SBCWD_MC_NORM_V2ON:
        begin
          if (wdog_mode_sel_q)
            run_mode_d = `SBCWD_WD_TIMEOUT;
          else
            run_mode_d = `SBCWD_WD_WINDOW;
        end
        `SBCWD_MC_STANDBY:
        begin
          if (wdog_mode_sel_q)
            run_mode_d = `SBCWD_WD_OFF;
          else
            run_mode_d = `SBCWD_WD_TIMEOUT;
        end
        default:
          run_mode_d = `SBCWD_WD_OFF;
      endcase
    end
  end

  // every input pin but clk_sys and rst_n is asynchronous to clk_sys and passes two flip-flops;
  // this costs two clocks of latency on every status bit
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      // idle pattern: chip select high and all else low, so the release
      // of reset cannot look like the start of a frame
      s1_q <= 9'h001;
      s2_q <= 9'h001;
    end
    else
    begin
      s1_q <= {wake_event, local_wake_input_2, local_wake_input_1,
               xcvr_reg_uv, main_reg_uv, wdog_disable_input, spi_sdi,
               spi_sck, spi_cs_n};
      s2_q <= s1_q;
    end
  end

  // sck is a plain input; its edges are found against the last sample
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end
    else
    begin
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_n_s;
    end
  end

  // receive shifter and bit counter; data is taken on falling sck
  // the counter stops at a full frame so the extra bits of an over-long frame are dropped
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_q <= {FRAME_W{1'b0}};
      cnt_q <= 5'h00;
    end
    else if (frame_start)
    begin
      rx_q <= {FRAME_W{1'b0}};
      cnt_q <= 5'h00;
    end
    else if (bit_taken)
    begin
      rx_q <= {rx_q[FRAME_W-2:0], sdi_s};
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // transmit shifter; the reply trails the header by three bits because
  // the register is only known once the address is complete
  // leftover bits of the last reply fill the first three slots
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tx_q <= {FRAME_W{1'b0}};
      spi_sdo <= 1'b0;
    end
    else
    begin
      if (addr_known)
        tx_q <= read_word({rx_q[1:0], sdi_s});
      else if (!cs_n_s && sck_rise)
        tx_q <= {tx_q[FRAME_W-2:0], 1'b0};
      if (!cs_n_s && sck_rise)
        spi_sdo <= tx_q[FRAME_W-1];
    end
  end

  // output enable follows the synchronised select, one clock late
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      spi_sdo_oe <= 1'b0;
    else
      spi_sdo_oe <= ~cs_n_s;
  end

  // watchdog control fields; status and reserved bits of a write are lost
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wdog_mode_sel_q <= 1'b0;
      wdog_period_code_q <= `SBCWD_NWP_RESET;
    end
    else if (write_ok && rx_addr == `SBCWD_ADDR_WDS)
    begin
      wdog_mode_sel_q <= rx_q[`SBCWD_WMC_BIT];
      wdog_period_code_q <= rx_q[`SBCWD_NWP_HI:`SBCWD_NWP_LO];
    end
  end

  // a wake event in sleep outranks a write landing in the same cycle; with the
  // wake input still high a write of sleep is undone a cycle later
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      op_mode_field_q <= `SBCWD_MC_STANDBY;
    else if (wake_ev_s && op_mode_field_q == `SBCWD_MC_SLEEP)
      op_mode_field_q <= `SBCWD_MC_STANDBY;
    else if (write_ok && rx_addr == `SBCWD_ADDR_MODE)
      op_mode_field_q <= rx_q[`SBCWD_MC_HI:`SBCWD_MC_LO];
  end

  // watchdog run mode seen by the timing engine
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      wdog_run_mode_q <= `SBCWD_WD_OFF;
    else
      wdog_run_mode_q <= run_mode_d;
  end

  // period code and its value in milliseconds; 13 bits so 4096 fits
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wdog_period_q <= `SBCWD_NWP_RESET;
      wdog_period_ms_q <= `SBCWD_MS_RESET;
    end
    else
    begin
      wdog_period_q <= wdog_period_code_q;
      wdog_period_ms_q <= period_ms(wdog_period_code_q);
    end
  end

  // software reset request stands as long as the disable input is high
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      sw_reset_q <= 1'b0;
    else
      sw_reset_q <= wdog_disable_input_s;
  end

  // regulator enables are registered decodes of the mode field
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      op_mode_q <= `SBCWD_MC_STANDBY;
      main_reg_en_q <= 1'b1;
      xcvr_reg_en_q <= 1'b0;
    end
    else
    begin
      op_mode_q <= op_mode_field_q;
      main_reg_en_q <= op_mode_field_q != `SBCWD_MC_SLEEP;
      xcvr_reg_en_q <= op_mode_field_q == `SBCWD_MC_NORM_V2ON;
    end
  end
endmodule
`default_nettype wire

// [bench/sbcwd_chk_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module sbcwd_chk (
  input wire clk_sys,
  input wire rst_n,
  input wire spi_cs_n,
  input wire spi_sdo_oe,
  input wire wdog_disable_input,
  input wire wake_event,
  input wire [1:0] op_mode_q,
  input wire [2:0] wdog_period_q,
  input wire [12:0] wdog_period_ms_q,
  input wire sw_reset_q,
  input wire main_reg_en_q,
  input wire xcvr_reg_en_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_wake;
    wake_event[*4] ##0 op_mode_q == 2'h1;
  endsequence
  a_xcvr_mode: assert property ($stable(op_mode_q)[*3] |->
    xcvr_reg_en_q == (op_mode_q == 2'h3)) else $error("xcvr enable");
  a_main_mode: assert property ($stable(op_mode_q)[*3] |->
    main_reg_en_q == (op_mode_q != 2'h1)) else $error("main enable");
  a_swr_follow: assert property ($stable(wdog_disable_input)[*4] |->
    sw_reset_q == wdog_disable_input) else $error("soft reset flag");
  a_ms_code: assert property ($stable(wdog_period_q)[*2] |->
    wdog_period_ms_q == (wdog_period_q > 3'h5 ?
    (wdog_period_q[0] ? 13'h1000 : 13'h0400) :
    13'h0008 << wdog_period_q)) else $error("period ms");
  a_period_rst: assert property ($rose(rst_n) |->
    wdog_period_q == 3'h4) else $error("period after reset");
  a_wake_sby: assert property (s_wake |-> ##[0:4] op_mode_q == 2'h0)
    else $error("wake mode");
  a_wake_main: assert property (s_wake |-> ##[1:6] main_reg_en_q)
    else $error("wake main");
  a_cs_hold: assert property ((!spi_cs_n && !wake_event &&
    !wdog_disable_input)[*6] |-> $stable(op_mode_q) && $stable(wdog_period_q))
    else $error("write while selected");
  a_oe_idle: assert property (spi_cs_n[*4] |-> !spi_sdo_oe)
    else $error("sdo driven");
endmodule
bind sbcwd_regs sbcwd_chk sbcwd_chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
  .wdog_disable_input(wdog_disable_input), .wake_event(wake_event),
  .op_mode_q(op_mode_q), .wdog_period_q(wdog_period_q),
  .wdog_period_ms_q(wdog_period_ms_q), .sw_reset_q(sw_reset_q),
  .main_reg_en_q(main_reg_en_q), .xcvr_reg_en_q(xcvr_reg_en_q));
`default_nettype wire

// [bench/sbcwd_spi_host.sv]
`timescale 1ns/10ps
`default_nettype none
module sbcwd_spi_host (
  output var logic spi_cs_n,
  output var logic spi_sck,
  output var logic spi_sdi,
  input wire logic spi_sdo
);
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
  end
  task automatic xfer(input logic [15:0] f, output logic [15:0] r);
    r = 16'h0000;
    #1 spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      #62.5 spi_sck = 1'b1;
      spi_sdi = f[i];
      #62.5 r = {r[14:0], spi_sdo};
      spi_sck = 1'b0;
    end
    #62.5 spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
  endtask
endmodule
`default_nettype wire

// [bench/tb_sbcwd_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_sbcwd_regs;
  logic clk_sys = 0, rst_n = 0, wdog_disable_input = 0, wake_event = 0;
  logic main_reg_uv = 0, xcvr_reg_uv = 0, local_wake_input_1 = 0;
  logic local_wake_input_2 = 0;
  wire spi_cs_n, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe, sw_reset_q;
  wire main_reg_en_q, xcvr_reg_en_q;
  wire [1:0] wdog_run_mode_q, op_mode_q;
  wire [2:0] wdog_period_q;
  wire [12:0] wdog_period_ms_q;
  int num_errors = 0, compares = 0;
  initial forever #5 clk_sys = ~clk_sys;
  sbcwd_regs sbcwd_regs_i (.clk_sys, .rst_n, .spi_cs_n, .spi_sck, .spi_sdi,
    .spi_sdo, .spi_sdo_oe, .wdog_disable_input, .main_reg_uv,
    .xcvr_reg_uv, .local_wake_input_1, .local_wake_input_2,
    .wake_event, .wdog_run_mode_q, .wdog_period_q, .wdog_period_ms_q,
    .sw_reset_q, .op_mode_q, .main_reg_en_q, .xcvr_reg_en_q);
  sbcwd_spi_host sbcwd_spi_host_i (.spi_cs_n, .spi_sck, .spi_sdi, .spi_sdo);
  task automatic settle;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] f);
    logic [15:0] r;
    sbcwd_spi_host_i.xfer(f, r);
    settle;
  endtask
  task automatic rd(input logic [15:0] f, output logic [15:0] r);
    sbcwd_spi_host_i.xfer(f, r);
    settle;
  endtask
  task automatic t_modes;
    logic [1:0] m;
    logic b;
    for (int k = 0; k < 6; k++)
    begin
      m = k < 2 ? 2'h2 : k < 4 ? 2'h3 : 2'h0;
      b = k[0];
      wr({4'h0, b, 11'h400});
      wr({4'h2, m, 10'h0});
      `CHK("run", m ? {b, ~b} : {~b, 1'b0}, wdog_run_mode_q)
    end
  endtask
  task automatic t_period;
    logic [12:0] e;
    for (int c = 0; c < 8; c++)
    begin
      e = c > 5 ? (c > 6 ? 13'h1000 : 13'h0400) : 13'h0008 << c;
      wr({5'h0, c[2:0], 8'h0});
      `CHK("ms", e, wdog_period_ms_q)
    end
    wr({4'h1, 12'h0});
    wr({4'h4, 12'h0});
    `CHK("ro", 3'h7, wdog_period_q)
  endtask
  task automatic t_status;
    logic [15:0] r;
    wr({5'h0, 3'h7, 8'hff});
    @(posedge clk_sys) main_reg_uv <= 1'b1;
    local_wake_input_1 <= 1'b1;
    settle;
    rd({4'h1, 12'h000}, r);
    `CHK("status a", 16'h00ea, r)
    `CHK("ro keep", 3'h7, wdog_period_q)
    @(posedge clk_sys) main_reg_uv <= 1'b0;
    xcvr_reg_uv <= 1'b1;
    local_wake_input_1 <= 1'b0;
    local_wake_input_2 <= 1'b1;
    wdog_disable_input <= 1'b1;
    settle;
    rd({4'h1, 12'h000}, r);
    `CHK("status b", 16'h00f5, r)
    `CHK("swr on", 1'b1, sw_reset_q)
    @(posedge clk_sys) wdog_disable_input <= 1'b0;
    xcvr_reg_uv <= 1'b0;
    local_wake_input_2 <= 1'b0;
    settle;
    `CHK("swr off", 1'b0, sw_reset_q)
    `CHK("wd sby", 2'h2, wdog_run_mode_q)
    wr({4'h2, 2'h3, 10'h3ff});
    rd({4'h3, 12'h000}, r);
    `CHK("mode rd", 16'h0580, r)
    `CHK("xcvr on", 1'b1, xcvr_reg_en_q)
  endtask
  task automatic t_wake;
    wr({4'h2, 2'h1, 10'h0});
    `CHK("main", 1'b0, main_reg_en_q)
    @(posedge clk_sys) wake_event <= 1'b1;
    settle;
    `CHK("mode", 2'h0, op_mode_q)
    @(posedge clk_sys) wake_event <= 1'b0;
    wdog_disable_input <= 1'b1;
    settle;
    `CHK("swr", 1'b1, sw_reset_q)
    `CHK("off", 2'h0, wdog_run_mode_q)
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle;
    `CHK("per", 3'h4, wdog_period_q)
    t_modes;
    t_period;
    t_status;
    t_wake;
    wrap_up;
  end
  initial
  begin
    #300000;
    num_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
